//--- core/ec_cfg_pkg.sv
// Package of offsets, field positions, reset values and counts for the controller configuration bank
package ec_cfg_pkg;

  // ************************************************************
  // Register offsets in firmware data space
  // ************************************************************
  localparam logic [15:0] OFS_SILICON_REVISION = 16'h7f06;
  localparam logic [15:0] OFS_PART_IDENT = 16'h7f07;
  localparam logic [15:0] OFS_OUTPUT_ENABLE = 16'h7f3e;
  localparam logic [15:0] OFS_FUNCTION_DISABLE = 16'h7f3f;
  localparam logic [15:0] OFS_BUS_MONITOR = 16'h7f8a;
  localparam logic [15:0] OFS_CONTROLLER_CONFIG = 16'h7ff4;
  // Locations whose writes act on the keyboard-interface flags and address gate
  localparam logic [15:0] OFS_OUTPUT_DATA = 16'h7ff1;
  localparam logic [15:0] OFS_AUX_OUTPUT_DATA = 16'h7ffa;
  localparam logic [15:0] OFS_HOST_FULL_LATCH = 16'h7ffd;
  localparam logic [15:0] OFS_GATE_CLEAR = 16'h7ffe;
  localparam logic [15:0] OFS_GATE_SET = 16'h7fff;
  // Scratch memory windows
  localparam logic [15:0] SCRATCH_DATA_BASE = 16'h7b00;
  localparam logic [15:0] SCRATCH_DATA_LAST = 16'h7cff;
  localparam logic [15:0] SCRATCH_CODE_BASE = 16'hfe00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int DIS_SERIAL_BIT = 6;
  localparam int DIS_USER_BIT = 3;
  localparam int DIS_FLASH_BIT = 2;
  localparam int CFG_AUX_HW_BIT = 7;
  localparam int CFG_IRQ_GATE_BIT = 5;
  localparam int CFG_MMAP_BIT = 3;
  localparam int CFG_HOST_SRC_BIT = 2;
  localparam int CFG_GATE_ASSIST_BIT = 1;
  localparam int CFG_SLEEP_BIT = 0;
  localparam int OE_OVERRIDE_BIT = 3;
  localparam int OE_PWRGOOD_BIT = 2;
  localparam int OE_RESET_OUT_BIT = 1;
  localparam int OE_SLOW_CLK_BIT = 0;
  localparam int MON_PD_BIT = 0;
  localparam int STAT_OUT_FULL_BIT = 0;
  localparam int STAT_AUX_FULL_BIT = 5;

  // ************************************************************
  // Writable masks and reset values
  // ************************************************************
  localparam logic [7:0] DIS_WR_MASK = 8'h4c;
  localparam logic [7:0] CFG_WR_MASK = 8'haf;
  localparam logic [7:0] OE_WR_MASK = 8'h0b;
  localparam logic [7:0] DIS_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] OE_RESET = 8'h02;
  localparam logic [7:0] STOP_COUNT_RESET = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FORCE_RESET_NS = 100;
  localparam int FORCE_RESET_CYCLES = (FORCE_RESET_NS * 1000) / CLK_PERIOD_PS;

endpackage

//--- core/ec_pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement
module ec_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;

  // Per-bit chain; output moves only when the last two stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        stage1_ff[i] <= 1'b0;
        stage2_ff[i] <= 1'b0;
        stage3_ff[i] <= 1'b0;
        pin_out[i] <= 1'b0;
      end else begin
        stage1_ff[i] <= pin_in[i];
        stage2_ff[i] <= stage1_ff[i];
        stage3_ff[i] <= stage2_ff[i];
        if (stage2_ff[i] == stage3_ff[i]) begin
          pin_out[i] <= stage3_ff[i];
        end
      end
    end
  end

endmodule

//--- core/ec_config_control_regs.sv
// Controller configuration and control register bank
//
// Operation
// - Disable bit 6 enables the serial port
// - Disable bit 3 is plain user storage
// - Disable bit 2 blocks host flash programming
// - Disable reserved bits read zero, ignore writes
// - Revision register is read-only revision code
// - Identification register is read-only part code
// - Aux-hardware bit lets aux writes set flag
// - Gate bit routes host full flag and aux-hardware write flag onto interrupts
// - Memory-map bit moves scratch RAM to code
// - Source bit picks latch or data-write full
// - Assist bit gives firmware the address gate
// - Power-control bit 0 enters idle or sleep
// - Wake-up and reset clear sleep select
// - No power-good forces reset-out bit set
// - Legacy clear counts down, releases reset, stops
// - Output-enable bit 2 mirrors power-good pin
// - Override gives reset-out direct pin control
// - Override keeps the controller clock running
// - Output-enable bit 0 gates slow clock out
// - Monitor bit 0 is inverse powerdown pin
module ec_config_control_regs
  import ec_cfg_pkg::*;
#(
  parameter logic [7:0] SILICON_REV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] PART_ID_CODE = 8'h5a // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic aux_rst,
  input wire logic [15:0] fw_addr,
  input wire logic fw_wr,
  input wire logic fw_rd,
  input wire logic [7:0] fw_wdata,
  output logic [7:0] fw_rdata,
  input wire logic power_good_pin,
  input wire logic bus_powerdown_pin_n,
  input wire logic slow_clock_in,
  input wire logic wake_event,
  input wire logic power_control_reg_idle,
  input wire logic host_gate_write,
  input wire logic host_gate_value,
  input wire logic stop_count_load,
  input wire logic [7:0] stop_count_value,
  input wire logic external_access_pin_n,
  output logic serial_port_enable,
  output logic host_flash_block,
  output logic keyboard_irq,
  output logic mouse_irq,
  output logic host_output_full,
  output logic aux_output_full,
  output logic addr20_gate,
  output logic scratch_in_code,
  output logic idle_req,
  output logic sleep_req,
  output logic system_reset_pin,
  output logic internal_reset,
  output logic stop_clock_flag,
  output logic cpu_clock_stop,
  output logic slow_clock_out_pin,
  output logic [7:0] status_out
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0] disable_ff;
  logic [7:0] config_ff;
  logic [7:0] oe_ff;
  logic [7:0] stop_count_ff;
  logic stop_clock_ff;
  logic clock_stopped_ff;
  logic host_full_latch_ff;
  logic data_full_ff;
  logic aux_full_ff;
  logic aux_irq_src_ff;
  logic gate_ff;
  logic [2:0] sync_out;
  logic aux_rst_s;
  logic pwrgood_s;
  logic pd_s;
  logic nxt_host_full;
  logic reset_out_wr_clear;
  logic [7:0] nxt_rdata;

  // Secondary supply reset comes from another supply domain, so it shares the pin chain
  ec_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({aux_rst, power_good_pin, bus_powerdown_pin_n}),
    .pin_out(sync_out)
  );

  assign aux_rst_s = sync_out[2];
  assign pwrgood_s = sync_out[1];
  assign pd_s = sync_out[0];

  // Decoded strobes
  logic wr_dis, wr_cfg, wr_oe, wr_data, wr_aux, wr_latch, wr_gclr, wr_gset;
  assign wr_dis = fw_wr && (fw_addr == OFS_FUNCTION_DISABLE);
  assign wr_cfg = fw_wr && (fw_addr == OFS_CONTROLLER_CONFIG);
  assign wr_oe = fw_wr && (fw_addr == OFS_OUTPUT_ENABLE);
  assign wr_data = fw_wr && (fw_addr == OFS_OUTPUT_DATA);
  assign wr_aux = fw_wr && (fw_addr == OFS_AUX_OUTPUT_DATA);
  assign wr_latch = fw_wr && (fw_addr == OFS_HOST_FULL_LATCH);
  assign wr_gclr = fw_wr && (fw_addr == OFS_GATE_CLEAR);
  assign wr_gset = fw_wr && (fw_addr == OFS_GATE_SET);

  // ************************************************************
  // Disable register
  // ************************************************************
  // Only serial, user and flash bits take writes
  always_ff @(posedge clk) begin
    if (rst) begin
      disable_ff <= DIS_RESET;
    end else if (wr_dis) begin
      disable_ff <= fw_wdata & DIS_WR_MASK;
    end
  end

  // ************************************************************
  // Configuration register
  // ************************************************************
  // Sleep select cleared by wake, wake wins over a firmware set
  always_ff @(posedge clk) begin
    if (rst) begin
      config_ff <= CFG_RESET;
    end else begin
      if (wr_cfg) begin
        config_ff <= fw_wdata & CFG_WR_MASK;
      end
      if (wake_event) begin
        config_ff[CFG_SLEEP_BIT] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Output enable register and legacy stop sequence
  // ************************************************************
  // Firmware clear of reset-out only honoured with power good
  assign reset_out_wr_clear = wr_oe && !fw_wdata[OE_RESET_OUT_BIT] && pwrgood_s;

  // Forced set takes five cycles from the pin, well inside the allowed window
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_ff <= OE_RESET;
    end else begin
      if (wr_oe) begin
        oe_ff[OE_OVERRIDE_BIT] <= fw_wdata[OE_OVERRIDE_BIT];
        oe_ff[OE_SLOW_CLK_BIT] <= fw_wdata[OE_SLOW_CLK_BIT];
        if (pwrgood_s) begin
          oe_ff[OE_RESET_OUT_BIT] <= fw_wdata[OE_RESET_OUT_BIT];
        end
      end
      // Secondary supply reset: override off, reset-out set, slow clock bit kept
      if (aux_rst_s) begin
        oe_ff[OE_OVERRIDE_BIT] <= 1'b0;
        oe_ff[OE_RESET_OUT_BIT] <= 1'b1;
      end
      if (!pwrgood_s) begin
        oe_ff[OE_RESET_OUT_BIT] <= 1'b1;
      end
    end
  end

  // Count loaded by the timer side; legacy clear starts it
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_count_ff <= STOP_COUNT_RESET;
      stop_clock_ff <= 1'b0;
    end else begin
      if (stop_count_load) begin
        stop_count_ff <= stop_count_value;
      end else if (stop_clock_ff && stop_count_ff != 8'h00) begin
        stop_count_ff <= stop_count_ff - 8'h01;
      end
      if (reset_out_wr_clear && !oe_ff[OE_OVERRIDE_BIT] && stop_count_ff != 8'h00) begin
        stop_clock_ff <= 1'b1;
      end else if (wr_oe && fw_wdata[OE_RESET_OUT_BIT]) begin
        stop_clock_ff <= 1'b0;
      end
    end
  end

  // Clock stop only in legacy mode, never under override
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_stopped_ff <= 1'b0;
    end else if (oe_ff[OE_OVERRIDE_BIT]) begin
      clock_stopped_ff <= 1'b0;
    end else if (stop_clock_ff && stop_count_ff == 8'h00) begin
      clock_stopped_ff <= 1'b1;
    end else if (oe_ff[OE_RESET_OUT_BIT]) begin
      clock_stopped_ff <= 1'b0;
    end
  end

  // Reset pin: active low; override drives it straight from the bit
  always_ff @(posedge clk) begin
    if (rst) begin
      system_reset_pin <= 1'b0;
      internal_reset <= 1'b1;
      stop_clock_flag <= 1'b0;
      cpu_clock_stop <= 1'b0;
    end else begin
      if (oe_ff[OE_OVERRIDE_BIT]) begin
        system_reset_pin <= !oe_ff[OE_RESET_OUT_BIT];
        internal_reset <= oe_ff[OE_RESET_OUT_BIT];
      end else begin
        system_reset_pin <= clock_stopped_ff;
        internal_reset <= !clock_stopped_ff;
      end
      stop_clock_flag <= stop_clock_ff;
      cpu_clock_stop <= clock_stopped_ff && !oe_ff[OE_OVERRIDE_BIT];
    end
  end

  // ************************************************************
  // Keyboard interface flags and address gate
  // ************************************************************
  // Output-data write sets the data flag; aux write never sets it
  always_ff @(posedge clk) begin
    if (rst) begin
      data_full_ff <= 1'b0;
      host_full_latch_ff <= 1'b0;
    end else begin
      if (wr_data) begin
        data_full_ff <= 1'b1;
      end
      if (wr_latch) begin
        host_full_latch_ff <= fw_wdata[0];
      end
    end
  end

  assign nxt_host_full = config_ff[CFG_HOST_SRC_BIT] ? host_full_latch_ff : data_full_ff;

  // Aux full: hardware set or plain user bit
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_full_ff <= 1'b0;
      aux_irq_src_ff <= 1'b0;
    end else begin
      if (config_ff[CFG_AUX_HW_BIT]) begin
        if (wr_aux) begin
          aux_full_ff <= 1'b1;
          aux_irq_src_ff <= 1'b1;
        end
      end else if (wr_aux) begin
        aux_full_ff <= fw_wdata[STAT_AUX_FULL_BIT];
      end
    end
  end

  // Gate follows latest host command or firmware write unless assisted
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_ff <= 1'b0;
    end else if (wr_gset) begin
      gate_ff <= 1'b1;
    end else if (wr_gclr) begin
      gate_ff <= 1'b0;
    end else if (host_gate_write && !config_ff[CFG_GATE_ASSIST_BIT]) begin
      gate_ff <= host_gate_value;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_port_enable <= 1'b0;
      host_flash_block <= 1'b0;
      keyboard_irq <= 1'b0;
      mouse_irq <= 1'b0;
      host_output_full <= 1'b0;
      aux_output_full <= 1'b0;
      addr20_gate <= 1'b0;
      scratch_in_code <= 1'b0;
      idle_req <= 1'b0;
      sleep_req <= 1'b0;
      slow_clock_out_pin <= 1'b0;
      status_out <= 8'h00;
    end else begin
      serial_port_enable <= disable_ff[DIS_SERIAL_BIT];
      host_flash_block <= disable_ff[DIS_FLASH_BIT];
      keyboard_irq <= config_ff[CFG_IRQ_GATE_BIT] && nxt_host_full;
      mouse_irq <= config_ff[CFG_IRQ_GATE_BIT] && aux_irq_src_ff;
      host_output_full <= nxt_host_full;
      aux_output_full <= aux_full_ff;
      addr20_gate <= gate_ff;
      scratch_in_code <= config_ff[CFG_MMAP_BIT];
      idle_req <= power_control_reg_idle && !config_ff[CFG_SLEEP_BIT];
      sleep_req <= power_control_reg_idle && config_ff[CFG_SLEEP_BIT];
      slow_clock_out_pin <= oe_ff[OE_SLOW_CLK_BIT] && slow_clock_in;
      status_out <= {2'b00, aux_full_ff, 4'b0000, nxt_host_full};
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (fw_addr)
      OFS_SILICON_REVISION: nxt_rdata = SILICON_REV_CODE;
      OFS_PART_IDENT: nxt_rdata = PART_ID_CODE;
      OFS_FUNCTION_DISABLE: nxt_rdata = disable_ff & DIS_WR_MASK;
      OFS_CONTROLLER_CONFIG: nxt_rdata = config_ff & CFG_WR_MASK;
      OFS_OUTPUT_ENABLE: begin
        nxt_rdata = oe_ff & OE_WR_MASK;
        nxt_rdata[OE_PWRGOOD_BIT] = pwrgood_s;
      end
      OFS_BUS_MONITOR: nxt_rdata[MON_PD_BIT] = !pd_s;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data registered; no reset dependence for the monitor bit beyond sync
  always_ff @(posedge clk) begin
    if (rst) begin
      fw_rdata <= 8'h00;
    end else if (fw_rd) begin
      fw_rdata <= nxt_rdata;
    end
  end

endmodule

//--- bench/ec_config_control_regs_props.sv
// Port-level checker for the controller configuration bank
module ec_cfg_props
  import ec_cfg_pkg::*;
#(
  parameter logic [7:0] SILICON_REV_CODE = 8'h01,
  parameter logic [7:0] PART_ID_CODE = 8'h5a
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] fw_addr,
  input wire logic fw_wr,
  input wire logic fw_rd,
  input wire logic [7:0] fw_wdata,
  input wire logic [7:0] fw_rdata,
  input wire logic power_good_pin,
  input wire logic bus_powerdown_pin_n,
  input wire logic serial_port_enable,
  input wire logic host_flash_block,
  input wire logic keyboard_irq,
  input wire logic mouse_irq,
  input wire logic host_output_full,
  input wire logic aux_output_full,
  input wire logic sleep_req,
  input wire logic system_reset_pin,
  input wire logic cpu_clock_stop,
  input wire logic slow_clock_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pd_cnt_ff;
  logic [5:0] pg_low_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Pin stability counters, since pins pass a synchroniser before they show
  always_ff @(posedge clk) begin
    if (rst || $changed(bus_powerdown_pin_n)) pd_cnt_ff <= 6'h00;
    else if (pd_cnt_ff != 6'h3f) pd_cnt_ff <= pd_cnt_ff + 6'h01;
  end
  always_ff @(posedge clk) begin
    if (rst || power_good_pin) pg_low_ff <= 6'h00;
    else if (pg_low_ff != 6'h3f) pg_low_ff <= pg_low_ff + 6'h01;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_serial_follow: assert property (fw_wr && fw_addr == OFS_FUNCTION_DISABLE
    |-> ##2 serial_port_enable == $past(fw_wdata[DIS_SERIAL_BIT], 2)) else $error("serial enable wrong");
  a_flash_follow: assert property (fw_wr && fw_addr == OFS_FUNCTION_DISABLE
    |-> ##2 host_flash_block == $past(fw_wdata[DIS_FLASH_BIT], 2)) else $error("flash block wrong");
  a_dis_reserved: assert property (fw_rd && fw_addr == OFS_FUNCTION_DISABLE
    |=> (fw_rdata & ~DIS_WR_MASK) == 8'h00) else $error("reserved bits set");
  a_rev_value: assert property (fw_rd && fw_addr == OFS_SILICON_REVISION |=> fw_rdata == SILICON_REV_CODE)
    else $error("revision read wrong");
  a_id_value: assert property (fw_rd && fw_addr == OFS_PART_IDENT |=> fw_rdata == PART_ID_CODE)
    else $error("identification read wrong");
  a_kbd_irq_gate: assert property (!host_output_full [*3] |-> !keyboard_irq)
    else $error("keyboard irq without flag");
  a_mouse_irq_gate: assert property (!aux_output_full [*3] |-> !mouse_irq)
    else $error("mouse irq without flag");
  a_pwrgood_force: assert property (fw_rd && fw_addr == OFS_OUTPUT_ENABLE && pg_low_ff >= 6'd28
    |=> fw_rdata[OE_RESET_OUT_BIT]) else $error("reset out not forced");
  a_oe_reserved: assert property (fw_rd && fw_addr == OFS_OUTPUT_ENABLE |=> fw_rdata[7:4] == 4'h0)
    else $error("enable reserved set");
  a_mon_inverse: assert property (fw_rd && fw_addr == OFS_BUS_MONITOR && pd_cnt_ff >= 6'd6
    |=> fw_rdata == {7'h00, !$past(bus_powerdown_pin_n)}) else $error("monitor not inverse");
  a_slowclk_off: assert property (fw_wr && fw_addr == OFS_OUTPUT_ENABLE && !fw_wdata[OE_SLOW_CLK_BIT]
    ##1 !fw_wr [*3] |-> !slow_clock_out_pin) else $error("slow clock not low");

  // Main scenarios reached
  c_kbd_irq: cover property (keyboard_irq && mouse_irq);
  c_sleep: cover property (sleep_req);
  c_clock_stop: cover property ($rose(cpu_clock_stop));
  c_pin_release: cover property ($rose(system_reset_pin));
endmodule

bind ec_config_control_regs ec_cfg_props #(.SILICON_REV_CODE(SILICON_REV_CODE), .PART_ID_CODE(PART_ID_CODE)) props_u (.*);

//--- bench/tb_ec_config_control_regs.sv
// Self-checking bench for the controller configuration bank
module tb_ec_config_control_regs;
  import ec_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk = 0, rst = 1, fw_wr = 0, fw_rd = 0, power_good_pin = 1, bus_powerdown_pin_n = 1, aux_rst = 0;
  logic wake_event = 0, power_control_reg_idle = 0, host_gate_write = 0, host_gate_value = 0;
  logic stop_count_load = 0, serial_port_enable, host_flash_block, keyboard_irq, mouse_irq;
  logic host_output_full, aux_output_full, addr20_gate, scratch_in_code, idle_req, sleep_req;
  logic system_reset_pin, internal_reset, stop_clock_flag, cpu_clock_stop, slow_clock_out_pin;
  logic [15:0] fw_addr = 16'h0000;
  logic [7:0] fw_wdata = 8'h00, fw_rdata, status_out, stop_count_value = 8'h00, d;
  logic [3:0] slow_div = 4'h0;
  int failures = 0, n_compared = 0, k;
  // Writes then readbacks; read-only and reserved bits must not move
  row_t rows [8] = '{'{OFS_FUNCTION_DISABLE, 8'hff, 8'h4c}, '{OFS_FUNCTION_DISABLE, 8'h00, 8'h00},
    '{OFS_CONTROLLER_CONFIG, 8'hff, 8'haf}, '{OFS_CONTROLLER_CONFIG, 8'h50, 8'h00},
    '{OFS_SILICON_REVISION, 8'hff, 8'h01}, '{OFS_PART_IDENT, 8'h00, 8'h5a},
    '{OFS_OUTPUT_ENABLE, 8'hff, 8'h0f}, '{OFS_OUTPUT_ENABLE, 8'hf8, 8'h0c}};

  always #2.5 clk = ~clk;
  // Slow clock source far below the core clock
  always @(posedge clk) slow_div <= slow_div + 4'h1;

  ec_config_control_regs dut_u (.clk(clk), .rst(rst), .aux_rst(aux_rst), .fw_addr(fw_addr), .fw_wr(fw_wr),
    .fw_rd(fw_rd), .fw_wdata(fw_wdata), .fw_rdata(fw_rdata), .power_good_pin(power_good_pin),
    .bus_powerdown_pin_n(bus_powerdown_pin_n), .slow_clock_in(slow_div[3]), .wake_event(wake_event),
    .power_control_reg_idle(power_control_reg_idle), .host_gate_write(host_gate_write),
    .host_gate_value(host_gate_value), .stop_count_load(stop_count_load), .stop_count_value(stop_count_value),
    .external_access_pin_n(1'b1), .serial_port_enable(serial_port_enable), .host_flash_block(host_flash_block),
    .keyboard_irq(keyboard_irq), .mouse_irq(mouse_irq), .host_output_full(host_output_full),
    .aux_output_full(aux_output_full), .addr20_gate(addr20_gate), .scratch_in_code(scratch_in_code),
    .idle_req(idle_req), .sleep_req(sleep_req), .system_reset_pin(system_reset_pin),
    .internal_reset(internal_reset), .stop_clock_flag(stop_clock_flag), .cpu_clock_stop(cpu_clock_stop),
    .slow_clock_out_pin(slow_clock_out_pin), .status_out(status_out));

  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    step(1);
    fw_addr = a;
    fw_wdata = v;
    fw_wr = 1;
    step(1);
    fw_wr = 0;
  endtask
  task rd(input logic [15:0] a);
    step(1);
    fw_addr = a;
    fw_rd = 1;
    step(1);
    fw_rd = 0;
    d = fw_rdata;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task do_reset;
    rst = 1;
    step(5);
    rst = 0;
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 260 cycles
  initial begin
    #50000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    do_reset;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(d, rows[i].e, "readback");
    end
    $display("test table done");
    do_reset;
    rd(OFS_FUNCTION_DISABLE);
    chk(d, DIS_RESET, "disable reset");
    rd(OFS_CONTROLLER_CONFIG);
    chk(d, CFG_RESET, "config reset");
    rd(OFS_OUTPUT_ENABLE);
    chk(d, 8'h06, "enable reset");
    wr(OFS_FUNCTION_DISABLE, 8'h44);
    step(3);
    chk({serial_port_enable, host_flash_block}, 2'b11, "disable outputs");
    wr(OFS_CONTROLLER_CONFIG, 8'h04);
    wr(OFS_HOST_FULL_LATCH, 8'h01);
    wr(OFS_AUX_OUTPUT_DATA, 8'h00);
    step(4);
    chk({host_output_full, aux_output_full, keyboard_irq, mouse_irq}, 4'h8, "gate off");
    $display("test reset and gate off done");
    do_reset;
    wr(OFS_CONTROLLER_CONFIG, 8'ha0);
    wr(OFS_AUX_OUTPUT_DATA, 8'h00);
    wr(OFS_OUTPUT_DATA, 8'h55);
    step(4);
    chk({host_output_full, aux_output_full, keyboard_irq, mouse_irq}, 4'hf, "gate on");
    chk(status_out, 8'h21, "status flags");
    // Empty latch as source first, so the gate bit never moves while output full
    wr(OFS_CONTROLLER_CONFIG, 8'ha4);
    wr(OFS_CONTROLLER_CONFIG, 8'h01);
    power_control_reg_idle = 1;
    step(4);
    chk({sleep_req, idle_req}, 2'b10, "sleep entry");
    wake_event = 1;
    step(1);
    wake_event = 0;
    step(4);
    chk({sleep_req, idle_req}, 2'b01, "wake to idle");
    power_control_reg_idle = 0;
    wr(OFS_CONTROLLER_CONFIG, 8'h00);
    host_gate_value = 1;
    host_gate_write = 1;
    step(1);
    host_gate_write = 0;
    step(4);
    chk(addr20_gate, 1'b1, "host gate");
    wr(OFS_GATE_CLEAR, 8'h00);
    step(3);
    chk(addr20_gate, 1'b0, "firmware gate clear");
    wr(OFS_CONTROLLER_CONFIG, 8'h0a);
    wr(OFS_GATE_SET, 8'h00);
    host_gate_value = 0;
    host_gate_write = 1;
    step(1);
    host_gate_write = 0;
    step(4);
    chk({addr20_gate, scratch_in_code}, 2'b11, "assist and map");
    for (k = 0; k < 2; k++) begin
      bus_powerdown_pin_n = k[0];
      step(6);
      rd(OFS_BUS_MONITOR);
      chk(d, {7'h00, !k[0]}, "monitor");
    end
    $display("test flags gate sleep monitor done");
    power_good_pin = 0;
    step(30);
    wr(OFS_OUTPUT_ENABLE, 8'h09);
    rd(OFS_OUTPUT_ENABLE);
    chk(d, 8'h0b, "forced reset out");
    chk(system_reset_pin, 1'b0, "pin held");
    power_good_pin = 1;
    step(6);
    wr(OFS_OUTPUT_ENABLE, 8'h09);
    step(3);
    rd(OFS_OUTPUT_ENABLE);
    chk(d, 8'h0d, "override release");
    chk({system_reset_pin, cpu_clock_stop}, 2'b10, "override pin");
    chk(internal_reset, 1'b0, "override internal reset");
    k = 0;
    repeat (40) begin
      step(1);
      k += int'(slow_clock_out_pin === 1'b1);
    end
    chk(8'(k != 0), 8'h01, "slow clock runs");
    // Secondary supply reset keeps the slow clock bit, drops override, sets reset-out
    aux_rst = 1;
    step(6);
    aux_rst = 0;
    step(6);
    rd(OFS_OUTPUT_ENABLE);
    chk(d, 8'h07, "secondary reset");
    wr(OFS_OUTPUT_ENABLE, 8'h02);
    stop_count_value = 8'h03;
    stop_count_load = 1;
    step(1);
    stop_count_load = 0;
    wr(OFS_OUTPUT_ENABLE, 8'h00);
    step(1);
    chk({stop_clock_flag, system_reset_pin}, 2'b10, "legacy start");
    step(20);
    chk({system_reset_pin, cpu_clock_stop}, 2'b11, "legacy end");
    $display("test power and legacy done");
    final_report;
  end
endmodule
